// [logic/fault_flags_pkg.sv]
package fault_flags_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int          ADDR_W             = 8;
   localparam int          WORD_W             = 32;
   localparam logic [7:0]  FAULT_FLAGS_OFFSET = 8'he2;
   localparam logic [31:0] FAULT_FLAGS_RESET  = 32'h00000000;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int POS_ANY_FAULT       = 31;
   localparam int POS_ROTOR_FREQ      = 29;
   localparam int POS_ROTOR_T1        = 28;
   localparam int POS_ROTOR_T2        = 27;
   localparam int POS_BUS_ILIMIT      = 26;
   localparam int POS_PARAM_RL        = 25;
   localparam int POS_PARAM_EMF       = 24;
   localparam int POS_ABN_RATE_LOCK   = 23;
   localparam int POS_ABN_EMF_LOCK    = 22;
   localparam int POS_MOTOR_ABSENT    = 21;
   localparam int POS_ANY_LOCK        = 20;
   localparam int POS_LOCK_ILIMIT     = 19;
   localparam int POS_HW_STALL_ILIMIT = 18;
   localparam int POS_SUPPLY_LOW      = 17;
   localparam int POS_SUPPLY_HIGH     = 16;
   localparam int POS_SPEED_LOOP_SAT  = 15;
   localparam int POS_CURR_LOOP_SAT   = 14;
   localparam int POS_WATCHDOG        = 3;

   // Implemented flag bits (31 is derived, the rest reserved)
   localparam logic [31:0] FLAG_MASK = 32'h3fffc008;
   // Bits that track their source live instead of holding
   localparam logic [31:0] LIVE_MASK = 32'h04000000;

endpackage

// [logic/flag_word_if.sv]
interface flag_word_if;
   logic [31:0] src;
   logic        clear;
   logic [31:0] flags;

   modport bank
   (
      input  src,
      input  clear,
      output flags
   );

   modport ctrl
   (
      output src,
      output clear,
      input  flags
   );
endinterface

// [logic/fault_flag_bank.sv]
module fault_flag_bank
#(
   parameter int          WIDTH     = 32,
   parameter logic [31:0] VALID_MASK = fault_flags_pkg::FLAG_MASK,
   parameter logic [31:0] LIVE       = fault_flags_pkg::LIVE_MASK
)
(
   // Clock and reset
   input  wire logic  mclk,
   input  wire logic  rst_n,
   // Flag word
   flag_word_if.bank  fw
);

   logic [WIDTH-1:0] flag_q;
   logic [WIDTH-1:0] flag_d;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         always_comb
         begin
            if (!VALID_MASK[i])
               flag_d[i] = 1'b0;
            else if (LIVE[i])
               flag_d[i] = fw.src[i];
            else
               // Set wins over a clear in the same cycle
               flag_d[i] = fw.src[i] | (flag_q[i] & ~fw.clear);
         end
      end
   endgenerate

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         flag_q <= fault_flags_pkg::FAULT_FLAGS_RESET;
      else
         flag_q <= flag_d;
   end

   assign fw.flags = flag_q;

endmodule

// [logic/status_read_port.sv]
module status_read_port
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Read request
   input  wire logic        rd_en,
   input  wire logic [7:0]  rd_addr,
   input  wire logic [31:0] word,
   // Read answer
   output logic      [31:0] rd_data,
   output logic             rd_valid
);

   logic [31:0] data_q;
   logic [31:0] data_d;
   logic        valid_q;
   logic        valid_d;

   always_comb
   begin
      valid_d = rd_en;
      data_d  = data_q;
      if (rd_en && rd_addr == fault_flags_pkg::FAULT_FLAGS_OFFSET)
         data_d = word;
      else if (rd_en)
         data_d = 32'h00000000;
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         data_q  <= fault_flags_pkg::FAULT_FLAGS_RESET;
         valid_q <= 1'b0;
      end
      else
      begin
         data_q  <= data_d;
         valid_q <= valid_d;
      end
   end

   assign rd_data  = data_q;
   assign rd_valid = valid_q;

endmodule

// [logic/motor_controller_fault_flags.sv]
module motor_controller_fault_flags
(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_n,
   // Fault sources from the control algorithm
   input  wire logic        rotor_detect_frequency_error,
   input  wire logic        rotor_detect_timing_one_error,
   input  wire logic        rotor_detect_timing_two_error,
   input  wire logic        bus_current_limit_active,
   input  wire logic        param_measure_rl_error,
   input  wire logic        param_measure_emf_error,
   input  wire logic        abnormal_rotation_rate_lock,
   input  wire logic        abnormal_emf_lock,
   input  wire logic        motor_absent_fault,
   input  wire logic        stall_current_fault,
   input  wire logic        hardware_stall_current_fault,
   input  wire logic        supply_low_fault,
   input  wire logic        supply_high_fault,
   input  wire logic        speed_loop_saturated,
   input  wire logic        current_loop_saturated,
   input  wire logic        watchdog_timeout,
   // Device-level fault clear
   input  wire logic        fault_clear,
   // Register read port
   input  wire logic        rd_en,
   input  wire logic [7:0]  rd_addr,
   output logic      [31:0] rd_data,
   output logic             rd_valid,
   // Summary
   output logic             any_fault
);

   // ---------------------------------------------------------------
   // Source word
   // ---------------------------------------------------------------
   flag_word_if fw ();

   logic [31:0] src;
   logic        any_lock;

   always_comb
   begin
      // Combined lock indicator over the five lock types
      any_lock = abnormal_rotation_rate_lock | abnormal_emf_lock
               | motor_absent_fault | stall_current_fault
               | hardware_stall_current_fault;
      src = 32'h00000000;
      src[fault_flags_pkg::POS_ROTOR_FREQ]      =
         rotor_detect_frequency_error;
      src[fault_flags_pkg::POS_ROTOR_T1]        =
         rotor_detect_timing_one_error;
      src[fault_flags_pkg::POS_ROTOR_T2]        =
         rotor_detect_timing_two_error;
      src[fault_flags_pkg::POS_BUS_ILIMIT]      =
         bus_current_limit_active;
      src[fault_flags_pkg::POS_PARAM_RL]        =
         param_measure_rl_error;
      src[fault_flags_pkg::POS_PARAM_EMF]       =
         param_measure_emf_error;
      src[fault_flags_pkg::POS_ABN_RATE_LOCK]   =
         abnormal_rotation_rate_lock;
      src[fault_flags_pkg::POS_ABN_EMF_LOCK]    =
         abnormal_emf_lock;
      src[fault_flags_pkg::POS_MOTOR_ABSENT]    =
         motor_absent_fault;
      src[fault_flags_pkg::POS_ANY_LOCK]        = any_lock;
      src[fault_flags_pkg::POS_LOCK_ILIMIT]     =
         stall_current_fault;
      src[fault_flags_pkg::POS_HW_STALL_ILIMIT] =
         hardware_stall_current_fault;
      src[fault_flags_pkg::POS_SUPPLY_LOW]      =
         supply_low_fault;
      src[fault_flags_pkg::POS_SUPPLY_HIGH]     =
         supply_high_fault;
      src[fault_flags_pkg::POS_SPEED_LOOP_SAT]  =
         speed_loop_saturated;
      src[fault_flags_pkg::POS_CURR_LOOP_SAT]   =
         current_loop_saturated;
      src[fault_flags_pkg::POS_WATCHDOG]        =
         watchdog_timeout;
   end

   assign fw.src   = src;
   assign fw.clear = fault_clear;

   // ---------------------------------------------------------------
   // Held flags
   // ---------------------------------------------------------------
   fault_flag_bank u_bank
   (
      .mclk  (mclk),
      .rst_n (rst_n),
      .fw    (fw)
   );

   logic [31:0] word;

   always_comb
   begin
      word = fw.flags & fault_flags_pkg::FLAG_MASK;
      word[fault_flags_pkg::POS_ANY_FAULT] = |word;
   end

   // ---------------------------------------------------------------
   // Summary output
   // ---------------------------------------------------------------
   logic any_q;
   logic any_d;

   always_comb
   begin
      any_d = word[fault_flags_pkg::POS_ANY_FAULT];
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
         any_q <= 1'b0;
      else
         any_q <= any_d;
   end

   assign any_fault = any_q;

   // ---------------------------------------------------------------
   // Read port; no write path exists, so the word is read-only
   // ---------------------------------------------------------------
   status_read_port u_read
   (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .rd_en    (rd_en),
      .rd_addr  (rd_addr),
      .word     (word),
      .rd_data  (rd_data),
      .rd_valid (rd_valid)
   );

endmodule

// [tb/fault_flags_props.sv]
module fault_flags_props
(
   // Clock and reset
   input wire logic        mclk,
   input wire logic        rst_n,
   // Sources
   input wire logic        supply_low_fault,
   input wire logic        bus_current_limit_active,
   // Read port
   input wire logic        rd_en,
   input wire logic [7:0]  rd_addr,
   input wire logic [31:0] rd_data,
   input wire logic        rd_valid,
   input wire logic        any_fault
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // -------------------------------------------------------------
   // Properties
   // -------------------------------------------------------------
   sequence rd_word;
      rd_en && rd_addr == 8'he2;
   endsequence
   chk_valid_pulse: assert property (rd_en |=> rd_valid)
      else $error("read not answered");
   chk_no_spurious: assert property (!rd_en |=> !rd_valid)
      else $error("answer without read");
   chk_data_holds: assert property (!rd_en |=> $stable(rd_data))
      else $error("read data moved between reads");
   chk_unmapped_zero: assert property
      (rd_en && rd_addr != 8'he2 |=> rd_data == 32'h0)
      else $error("unmapped read not zero");
   chk_summary_or: assert property
      (rd_valid |-> rd_data[31] == |rd_data[30:0])
      else $error("summary bit wrong");
   chk_reserved_zero: assert property
      (rd_valid |-> (rd_data & 32'h40003ff7) == 32'h0)
      else $error("reserved bit set");
   chk_lock_any: assert property
      (rd_valid && |{rd_data[23:21], rd_data[19:18]} |-> rd_data[20])
      else $error("lock summary missing");
   chk_low_sets: assert property
      (supply_low_fault ##1 rd_word |=> rd_data[17])
      else $error("undervoltage flag missing");
   chk_limit_live: assert property
      (!bus_current_limit_active [*2] ##1 rd_word |=> !rd_data[26])
      else $error("current limit flag stuck");
   chk_fault_copy: assert property
      (rd_word |=> any_fault == rd_data[31])
      else $error("summary output disagrees");
endmodule

bind motor_controller_fault_flags fault_flags_props i_props (.*);

// [tb/motor_controller_fault_flags_bench.sv]
module motor_controller_fault_flags_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 0, rst_n = 0, fault_clear = 0, rd_en = 0;
   logic [7:0]  rd_addr = 8'h00;
   logic [31:0] s = 32'h0, rd_data;
   logic        rd_valid, any_fault;
   int          bad_count = 0, n_checks = 0;
   always #20 mclk = ~mclk;
   // Source i drives word bit i
   motor_controller_fault_flags i_dut (.*,
      .rotor_detect_frequency_error(s[29]),
      .rotor_detect_timing_one_error(s[28]),
      .rotor_detect_timing_two_error(s[27]),
      .bus_current_limit_active(s[26]), .param_measure_rl_error(s[25]),
      .param_measure_emf_error(s[24]), .abnormal_rotation_rate_lock(s[23]),
      .abnormal_emf_lock(s[22]), .motor_absent_fault(s[21]),
      .stall_current_fault(s[19]), .hardware_stall_current_fault(s[18]),
      .supply_low_fault(s[17]), .supply_high_fault(s[16]),
      .speed_loop_saturated(s[15]), .current_loop_saturated(s[14]),
      .watchdog_timeout(s[3]));
   // -------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------
   function automatic logic [31:0] e(logic [31:0] v);
      logic [31:0] w;
      w = v & fault_flags_pkg::FLAG_MASK;
      w[20] = |{v[23:21], v[19:18]};
      w[31] = |w;
      return w;
   endfunction
   task chk(logic [31:0] got, logic [31:0] x);
      n_checks++;
      if (got !== x)
      begin
         bad_count++;
         $display("Error %0t: got %h expected %h", $time, got, x);
      end
   endtask
   task st(logic [31:0] v, logic c);
      @(posedge mclk) s <= v;
      fault_clear <= c;
      @(posedge mclk) fault_clear <= 1'b0;
   endtask
   task rd(logic [7:0] a, logic [31:0] x);
      @(posedge mclk) rd_en <= 1'b1;
      rd_addr <= a;
      @(posedge mclk) rd_en <= 1'b0;
      @(negedge mclk) chk(rd_data, x);
      chk({31'h0, rd_valid}, 32'h1);
      if (a == 8'he2) chk({31'h0, any_fault}, {31'h0, x[31]});
   endtask
   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   task t_sticky;
      rd(8'he2, fault_flags_pkg::FAULT_FLAGS_RESET);
      st(32'h04020000, 1'b0);
      rd(8'he2, 32'h84020000);
      rd(8'he0, 32'h0);
      st(32'h0, 1'b0);
      rd(8'he2, 32'h80020000);
      st(32'h00020000, 1'b1);
      rd(8'he2, 32'h80020000);
      st(32'h0, 1'b1);
      rd(8'he2, 32'h0);
      $display("done t_sticky");
   endtask
   // One source raised alone, then cleared
   task t_bit(int i);
      st(32'h1 << i, 1'b0);
      rd(8'he2, e(32'h1 << i));
      st(32'h0, 1'b1);
      rd(8'he2, 32'h0);
   endtask
   task t_each;
      t_bit(29);
      t_bit(28);
      t_bit(27);
      t_bit(26);
      t_bit(25);
      t_bit(24);
      t_bit(23);
      t_bit(22);
      t_bit(21);
      t_bit(19);
      t_bit(18);
      t_bit(17);
      t_bit(16);
      t_bit(15);
      t_bit(14);
      t_bit(3);
      $display("done t_each");
   endtask
   task t_all;
      st(32'hffffffff, 1'b0);
      rd(8'he2, 32'hbfffc008);
      rd(8'he3, 32'h0);
      st(32'h0, 1'b1);
      rd(8'he2, 32'h0);
      $display("done t_all");
   endtask
   // Held flags must not survive a reset in mid-run
   task t_reset;
      st(32'h00030000, 1'b0);
      st(32'h0, 1'b0);
      rd(8'he2, 32'h80030000);
      @(posedge mclk) rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      rd(8'he2, fault_flags_pkg::FAULT_FLAGS_RESET);
      $display("done t_reset");
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      #200us;
      bad_count++;
      end_of_test;
   end
   initial
   begin
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      t_sticky;
      t_each;
      t_all;
      t_reset;
      end_of_test;
   end
endmodule
